// *** hdl/sdt_pkg.sv ***
// Package: register map, field positions, reset values and timing of the trigger/result block
package sdt_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] OFS_TRIGGER = 8'h1C;
  localparam logic [7:0] OFS_SYNC_BUSY = 8'h20;
  localparam logic [7:0] OFS_RESULT = 8'h24;
  localparam logic [7:0] OFS_SEQ_EN = 8'h28;
  localparam logic [7:0] OFS_ANALOG = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_MODE = 8'h34;
  localparam logic [7:0] OFS_SYNC_REQ = 8'h38;

  // ==========================================================================
  // Field positions
  localparam int TRIG_FLUSH_BIT = 0;
  localparam int TRIG_START_BIT = 1;
  localparam int BUSY_CONVERSION_TRIGGER_BIT = 10;
  localparam int BUSY_ANALOG_BIT = 11;
  localparam int BUSY_WIDTH = 12;
  localparam int STAT_RDY_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_SEQ_BUSY_BIT = 7;
  localparam int MODE_FREERUN_BIT = 0;
  localparam int MODE_MUX_LSB = 4;
  localparam int SEQ_INPUTS = 3;
  localparam int RESULT_WIDTH = 24;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_SEQ_EN = 8'h00;
  localparam logic [7:0] RST_ANALOG = 8'h00;
  localparam logic [31:0] RST_RESULT = 32'h00000000;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int SYNC_NS = 40;
  localparam int SYNC_CYCLES = (SYNC_NS * CLK_MHZ + 999) / 1000;
  localparam int FLUSH_NS = 80;
  localparam int FLUSH_CYCLES = (FLUSH_NS * CLK_MHZ + 999) / 1000;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_FLUSH
  } sdt_state_type;

endpackage : sdt_pkg

// *** hdl/sdt_trigger_result.sv ***
// Trigger, sync-busy, result, sequence and analog control registers of the converter
`timescale 1ns/10ps

module sdt_trigger_result #(
  parameter int SYNC_CYCLES = sdt_pkg::SYNC_CYCLES,
  parameter int FLUSH_CYCLES = sdt_pkg::FLUSH_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter core
  input wire logic conv_done,
  input wire logic [23:0] conv_value,
  output logic conv_start,
  output logic conv_flush,
  output logic [1:0] conv_input,
  // Analog front end
  output logic buffer_test,
  output logic input_chopper_enable,
  output logic [4:0] bias_current_control
);

  // ==========================================================================
  // State record
  typedef struct packed {
    sdt_pkg::sdt_state_type state;
    logic start_pend;
    logic flush_pend;
    logic resume;
    logic [7:0] flush_cnt;
    logic [11:0] busy;
    logic [7:0] sync_cnt;
    logic [23:0] result;
    logic rdy;
    logic ovr;
    logic [2:0] seq_en;
    logic [2:0] seq_left;
    logic seq_busy;
    logic [7:0] analog;
    logic freerun;
    logic [1:0] mux_sel;
    logic [1:0] cur_in;
    logic [31:0] rdata;
    logic wait_n;
    logic start_o;
    logic flush_o;
  } sdt_regs_type;

  sdt_regs_type cur_ff;
  sdt_regs_type nxt_ff;

  // Lowest set bit of a three-input mask
  function automatic logic [1:0] lowest_in(input logic [2:0] m);
    lowest_in = m[0] ? 2'h0 : (m[1] ? 2'h1 : 2'h2);
  endfunction : lowest_in

  // Mask with the lowest set bit removed
  function automatic logic [2:0] drop_lowest(input logic [2:0] m);
    drop_lowest = m & (m - 3'h1);
  endfunction : drop_lowest

  logic access;
  logic wr;
  logic rd;
  logic [2:0] rest;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.start_o = 1'b0;
    nxt_ff.flush_o = 1'b0;
    // One wait cycle per access; the access completes on the second edge
    access = (avs_read | avs_write) & ~cur_ff.wait_n;
    wr = avs_write & cur_ff.wait_n;
    rd = avs_read & cur_ff.wait_n;
    nxt_ff.wait_n = access;
    rest = drop_lowest(cur_ff.seq_left);

    if (cur_ff.sync_cnt != 8'h00) begin
      nxt_ff.sync_cnt = cur_ff.sync_cnt - 8'h01;
      if (cur_ff.sync_cnt == 8'h01) begin
        nxt_ff.busy = 12'h000;
      end
    end

    // Register writes
    if (wr) begin
      unique case (avs_address)
        sdt_pkg::OFS_TRIGGER: begin
          if (avs_byteenable[0]) begin
            nxt_ff.busy[sdt_pkg::BUSY_CONVERSION_TRIGGER_BIT] = 1'b1;
            nxt_ff.sync_cnt = 8'(SYNC_CYCLES);
            // Start request; ignored while pending; zero no effect
            if (avs_writedata[sdt_pkg::TRIG_START_BIT]) begin
              nxt_ff.start_pend = 1'b1;
            end
            if (avs_writedata[sdt_pkg::TRIG_FLUSH_BIT]) begin
              nxt_ff.flush_pend = 1'b1;
            end
          end
        end
        sdt_pkg::OFS_SEQ_EN: begin
          if (avs_byteenable[0]) begin
            nxt_ff.seq_en = avs_writedata[2:0];
          end
        end
        sdt_pkg::OFS_ANALOG: begin
          if (avs_byteenable[0]) begin
            nxt_ff.analog = avs_writedata[7:0] & 8'hDF;
            nxt_ff.busy[sdt_pkg::BUSY_ANALOG_BIT] = 1'b1;
            nxt_ff.sync_cnt = 8'(SYNC_CYCLES);
          end
        end
        sdt_pkg::OFS_STATUS: begin
          if (avs_byteenable[0]) begin
            if (avs_writedata[sdt_pkg::STAT_RDY_BIT]) begin
              nxt_ff.rdy = 1'b0;
            end
            if (avs_writedata[sdt_pkg::STAT_OVR_BIT]) begin
              nxt_ff.ovr = 1'b0;
            end
          end
        end
        sdt_pkg::OFS_MODE: begin
          if (avs_byteenable[0]) begin
            nxt_ff.freerun = avs_writedata[sdt_pkg::MODE_FREERUN_BIT];
            nxt_ff.mux_sel = avs_writedata[sdt_pkg::MODE_MUX_LSB +: 2];
          end
        end
        sdt_pkg::OFS_SYNC_REQ: begin
          // Neighbour registers report writes for their busy bits
          if (avs_byteenable[1:0] != 2'h0 && avs_writedata[11:0] != 12'h000) begin
            nxt_ff.busy = cur_ff.busy | avs_writedata[11:0];
            nxt_ff.sync_cnt = 8'(SYNC_CYCLES);
          end
        end
        default: begin
        end
      endcase
    end

    // Reading the result clears ready; overrun reference is then read
    if (rd && avs_address == sdt_pkg::OFS_RESULT) begin
      nxt_ff.rdy = 1'b0;
    end

    // Sequencer
    unique case (cur_ff.state)
      sdt_pkg::ST_IDLE: begin
        if (cur_ff.flush_pend) begin
          nxt_ff.state = sdt_pkg::ST_FLUSH;
          nxt_ff.flush_cnt = 8'(FLUSH_CYCLES);
          nxt_ff.flush_o = 1'b1;
          nxt_ff.resume = 1'b0;
        end else if (cur_ff.start_pend) begin
          // Start clears once the conversion begins
          nxt_ff.start_pend = 1'b0;
          nxt_ff.start_o = 1'b1;
          nxt_ff.state = sdt_pkg::ST_CONV;
          if (cur_ff.seq_en != 3'h0) begin
            // Lowest enabled input first; busy rises
            nxt_ff.cur_in = lowest_in(cur_ff.seq_en);
            nxt_ff.seq_left = cur_ff.seq_en;
            nxt_ff.seq_busy = 1'b1;
          end else begin
            nxt_ff.cur_in = cur_ff.mux_sel;
            nxt_ff.seq_left = 3'h0;
          end
        end
      end
      sdt_pkg::ST_CONV: begin
        if (cur_ff.flush_pend) begin
          // Abort, result of this conversion is lost
          nxt_ff.state = sdt_pkg::ST_FLUSH;
          nxt_ff.flush_cnt = 8'(FLUSH_CYCLES);
          nxt_ff.flush_o = 1'b1;
          nxt_ff.resume = 1'b1;
        end else if (conv_done) begin
          nxt_ff.result = conv_value;
          // Ready sets; set wins over a clear in this cycle
          nxt_ff.rdy = 1'b1;
          if (cur_ff.rdy) begin
            nxt_ff.ovr = 1'b1;
          end
          if (rest != 3'h0) begin
            nxt_ff.cur_in = lowest_in(rest);
            nxt_ff.seq_left = rest;
            nxt_ff.start_o = 1'b1;
          end else if (cur_ff.freerun) begin
            // Free running repeats the whole pass
            nxt_ff.seq_left = cur_ff.seq_en;
            nxt_ff.cur_in = cur_ff.seq_en != 3'h0 ? lowest_in(cur_ff.seq_en) : cur_ff.mux_sel;
            nxt_ff.start_o = 1'b1;
          end else begin
            nxt_ff.seq_busy = 1'b0;
            nxt_ff.state = sdt_pkg::ST_IDLE;
          end
        end
      end
      sdt_pkg::ST_FLUSH: begin
        // Flush bit held until the count runs out
        if (cur_ff.flush_cnt > 8'h01) begin
          nxt_ff.flush_cnt = cur_ff.flush_cnt - 8'h01;
        end else begin
          nxt_ff.flush_pend = 1'b0;
          nxt_ff.flush_cnt = 8'h00;
          if (cur_ff.resume) begin
            nxt_ff.state = sdt_pkg::ST_CONV;
            nxt_ff.start_o = 1'b1;
          end else begin
            nxt_ff.state = sdt_pkg::ST_IDLE;
          end
        end
      end
    endcase

    // Read data mux, registered so it is valid when waitrequest drops
    nxt_ff.rdata = 32'h00000000;
    if (access && avs_read) begin
      unique case (avs_address)
        sdt_pkg::OFS_TRIGGER: nxt_ff.rdata = {30'h0, cur_ff.start_pend, cur_ff.flush_pend};
        sdt_pkg::OFS_SYNC_BUSY: nxt_ff.rdata = {20'h0, cur_ff.busy};
        sdt_pkg::OFS_RESULT: nxt_ff.rdata = {8'h00, cur_ff.result};
        sdt_pkg::OFS_SEQ_EN: nxt_ff.rdata = {29'h0, cur_ff.seq_en};
        sdt_pkg::OFS_ANALOG: nxt_ff.rdata = {24'h0, cur_ff.analog};
        sdt_pkg::OFS_STATUS: nxt_ff.rdata = {24'h0, cur_ff.seq_busy, 5'h0, cur_ff.ovr, cur_ff.rdy};
        sdt_pkg::OFS_MODE: nxt_ff.rdata = {26'h0, cur_ff.mux_sel, 3'h0, cur_ff.freerun};
        default: nxt_ff.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nxt_ff_reset: begin
        cur_ff <= '0;
        cur_ff.state <= sdt_pkg::ST_IDLE;
        cur_ff.seq_en <= sdt_pkg::RST_SEQ_EN[2:0];
        cur_ff.analog <= sdt_pkg::RST_ANALOG;
      end
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================================
  // Outputs straight from flip-flops
  assign avs_readdata = cur_ff.rdata;
  // Waitrequest is high except on the completing cycle of an access
  assign avs_waitrequest = ~cur_ff.wait_n;
  assign conv_start = cur_ff.start_o;
  assign conv_flush = cur_ff.flush_o;
  assign conv_input = cur_ff.cur_in;
  assign buffer_test = cur_ff.analog[7];
  // Chopper enable to the front end
  assign input_chopper_enable = cur_ff.analog[6];
  assign bias_current_control = cur_ff.analog[4:0];

endmodule : sdt_trigger_result

// *** verification/sdt_chk.sv ***
// Checker: bus handshake, trigger, flush, result and analog control properties
`timescale 1ns/10ps
module sdt_chk #(
  parameter int SYNC_CYCLES = 4,
  parameter int FLUSH_CYCLES = 8
) (
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Converter and analog side
  input wire logic conv_done,
  input wire logic [23:0] conv_value,
  input wire logic conv_start,
  input wire logic conv_flush,
  input wire logic [1:0] conv_input,
  input wire logic buffer_test,
  input wire logic input_chopper_enable,
  input wire logic [4:0] bias_current_control
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [7:0] ana_ff;
  int age_ff;
  // Last analog byte written, and cycles since a flush began (saturates)
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ana_ff <= 8'h00;
      age_ff <= 1000;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == 8'h2C) begin
        ana_ff <= avs_writedata[7:0];
      end
      age_ff <= conv_flush ? 0 : (age_ff < 1000 ? age_ff + 1 : age_ff);
    end
  end
  // ==========================================================================
  // Properties
  sequence s_wr(logic [7:0] a);
    avs_write && !avs_waitrequest && avs_address == a && avs_byteenable[0];
  endsequence
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer lasted too long");
  property p_res;
    avs_read && !avs_waitrequest && avs_address == 8'h24 |-> avs_readdata[31:24] == 8'h00;
  endproperty
  a_res: assert property (p_res) else $error("result upper byte set");
  property p_busy;
    avs_read && !avs_waitrequest && avs_address == 8'h20 |-> avs_readdata[31:12] == 20'h0;
  endproperty
  a_busy: assert property (p_busy) else $error("busy upper bits set");
  property p_flush;
    s_wr(8'h1C) ##0 avs_writedata[0] |-> ##[1:4] conv_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not begun");
  property p_zero;
    s_wr(8'h1C) ##0 avs_writedata[1:0] == 2'b00 |-> ##1 !conv_flush [*3];
  endproperty
  a_zero: assert property (p_zero) else $error("zero write flushed");
  property p_hold;
    conv_start |-> age_ff >= FLUSH_CYCLES - 2;
  endproperty
  a_hold: assert property (p_hold) else $error("start during flush");
  property p_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_ana;
    s_wr(8'h2C) |-> ##[1:12] {buffer_test, input_chopper_enable, bias_current_control} ==
      {ana_ff[7:6], ana_ff[4:0]};
  endproperty
  a_ana: assert property (p_ana) else $error("analog outputs wrong");
  property p_input;
    conv_start |-> conv_input != 2'd3;
  endproperty
  a_input: assert property (p_input) else $error("input out of range");
endmodule : sdt_chk

// *** verification/testbench.sv ***
// Testbench: register, trigger, sequence, flush and result scenarios
`timescale 1ns/10ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  logic core_clk, srst, avs_read, avs_write, conv_done, avs_waitrequest, conv_start;
  logic conv_flush, buffer_test, input_chopper_enable;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [23:0] conv_value;
  logic [1:0] conv_input;
  logic [4:0] bias_current_control;
  int num_errors = 0, num_checks = 0, nstart = 0, nflush = 0, n0;
  // Sync and flush counts of 6 and 10, longer than the package's 4 and 8; byte lane 0 always on
  sdt_trigger_result #(.SYNC_CYCLES(6), .FLUSH_CYCLES(10)) dut (.core_clk(core_clk),
    .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_done(conv_done), .conv_value(conv_value),
    .conv_start(conv_start), .conv_flush(conv_flush), .conv_input(conv_input),
    .buffer_test(buffer_test), .input_chopper_enable(input_chopper_enable),
    .bias_current_control(bias_current_control));
  // Clock and pulse counters
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Pulses are counted mid-cycle, where they have settled
  always @(negedge core_clk) begin
    nstart += int'(conv_start === 1'b1);
    nflush += int'(conv_flush === 1'b1);
  end
  function automatic void chk(logic [31:0] g, logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endfunction : chk
  // One bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (w && a == 8'h1C) begin
      // Hold off until the trigger crossing is done
      do bus(0, 8'h20, 0); while (q[10] !== 1'b0);
    end
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // Waitrequest is looked at mid-cycle, where it has settled
    do begin
      @(negedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    // Edge at which waitrequest is low: the access completes here
    @(posedge core_clk);
    if (n >= 50) num_errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wait_start(input logic [1:0] ch);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (conv_start !== 1'b1 && n < 40);
    `CHK({n < 40, conv_input}, {1'b1, ch});
    @(posedge core_clk);
  endtask : wait_start
  // Converter answer; value is scrambled outside the done pulse
  task automatic done(input logic [23:0] v);
    repeat (2) @(posedge core_clk);
    conv_done <= 1'b1;
    conv_value <= v;
    @(posedge core_clk);
    conv_done <= 1'b0;
    conv_value <= ~v;
  endtask : done
  task automatic t_regs();
    logic [7:0] a [5] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h3C};
    foreach (a[i]) begin
      bus(0, a[i], 0);
      `CHK(q, 0);
    end
    bus(1, 8'h28, 32'h5);
    bus(0, 8'h28, 0);
    `CHK(q, 5);
    bus(1, 8'h28, 32'h0);
    repeat (10) @(posedge core_clk);
    bus(1, 8'h2C, 32'hC5);
    bus(0, 8'h20, 0);
    `CHK(q, 32'h800);
    repeat (12) @(posedge core_clk);
    `CHK({buffer_test, input_chopper_enable, bias_current_control}, 7'h65);
    bus(1, 8'h2C, 32'h1F);
    repeat (12) @(posedge core_clk);
    `CHK({buffer_test, input_chopper_enable, bias_current_control}, 7'h1F);
    for (int i = 0; i < 12; i++) begin
      bus(1, 8'h38, 32'h1 << i);
      bus(0, 8'h20, 0);
      `CHK(q, 32'h1 << i);
      repeat (10) @(posedge core_clk);
    end
    bus(0, 8'h20, 0);
    `CHK(q, 0);
  endtask : t_regs
  task automatic t_single();
    bus(1, 8'h34, 32'h10);
    bus(1, 8'h1C, 32'h2);
    wait_start(2'd1);
    bus(0, 8'h1C, 0);
    `CHK(q, 0);
    done(24'h800001);
    bus(0, 8'h24, 0);
    `CHK(q, 32'h00800001);
    bus(0, 8'h30, 0);
    `CHK(q[1:0], 0);
    for (int i = 0; i < 2; i++) begin
      bus(1, 8'h1C, 32'h2);
      wait_start(2'd1);
      done(24'hABC0 + 24'(i));
    end
    bus(0, 8'h30, 0);
    `CHK(q[1:0], 3);
    bus(1, 8'h30, 32'h3);
    bus(0, 8'h30, 0);
    `CHK(q[1:0], 0);
    bus(0, 8'h24, 0);
    `CHK(q, 32'hABC1);
  endtask : t_single
  // Start written twice while a conversion runs; exactly one extra conversion
  task automatic t_twice();
    bus(1, 8'h1C, 32'h2);
    wait_start(2'd1);
    n0 = nstart;
    bus(1, 8'h1C, 32'h2);
    bus(1, 8'h1C, 32'h2);
    bus(0, 8'h1C, 0);
    `CHK(q[1], 1);
    done(0);
    wait_start(2'd1);
    done(0);
    repeat (20) @(posedge core_clk);
    `CHK(nstart - n0, 1);
    n0 = nstart + nflush;
    bus(1, 8'h1C, 32'h0);
    repeat (12) @(posedge core_clk);
    `CHK(nstart + nflush - n0, 0);
  endtask : t_twice
  task automatic t_seq();
    n0 = nstart;
    bus(1, 8'h28, 32'h5);
    bus(1, 8'h1C, 32'h2);
    wait_start(2'd0);
    bus(0, 8'h30, 0);
    `CHK(q[7], 1);
    done(24'h1);
    wait_start(2'd2);
    done(24'h2);
    repeat (20) @(posedge core_clk);
    `CHK(nstart - n0, 2);
    bus(0, 8'h30, 0);
    `CHK(q[7], 0);
    bus(1, 8'h28, 32'h0);
  endtask : t_seq
  // Flush in mid-conversion restarts the aborted input
  task automatic t_flush();
    bus(1, 8'h1C, 32'h2);
    wait_start(2'd1);
    n0 = nflush;
    bus(1, 8'h1C, 32'h1);
    bus(0, 8'h1C, 0);
    `CHK(q[0], 1);
    `CHK(nflush - n0, 1);
    wait_start(2'd1);
    bus(0, 8'h1C, 0);
    `CHK(q, 0);
    done(0);
  endtask : t_flush
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // Reset, then the scenarios
  initial begin
    {srst, avs_read, avs_write, conv_done, avs_address, avs_writedata} = 44'h0;
    srst = 1'b1;
    conv_value = 24'h0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    t_regs();
    t_single();
    t_twice();
    t_seq();
    t_flush();
    finish_test();
  end
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    finish_test();
  end
endmodule : testbench
bind sdt_trigger_result sdt_chk #(.SYNC_CYCLES(SYNC_CYCLES), .FLUSH_CYCLES(FLUSH_CYCLES)) u_chk (
  .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_done(conv_done),
  .conv_value(conv_value), .conv_start(conv_start), .conv_flush(conv_flush),
  .conv_input(conv_input), .buffer_test(buffer_test),
  .input_chopper_enable(input_chopper_enable), .bias_current_control(bias_current_control));
